// >>> verilog/wp_decode_params.svh
// constants for the serial memory write-protect decoder
`ifndef WP_DECODE_PARAMS_SVH
`define WP_DECODE_PARAMS_SVH

// opcodes
`define OP_LATCH_SET 8'h06
`define OP_LATCH_CLEAR 8'h04
`define OP_STATUS_READ 8'h05
`define OP_STATUS_WRITE 8'h01
`define OP_MEM_READ 8'h03
`define OP_FAST_READ 8'h0B
`define OP_MEM_WRITE 8'h02
`define OP_SLEEP 8'hB9
`define OP_IDENT_READ 8'h9F

// status byte layout
`define ST_GUARD_EN_BIT 7
`define ST_BG_HI_BIT 3
`define ST_BG_LO_BIT 2
`define ST_WEL_BIT 1
`define ST_FIXED_VALUE 8'h40
`define ST_WRITABLE_MASK 8'h8C

// reset and shipped values
`define WEL_RESET 1'b0
`define GUARD_SHIPPED 3'h0
`define STATUS_IDLE 8'h40

// address space
`define ADDR_W 19
`define ADDR_ZERO 19'h00000
`define ADDR_ONE 19'h00001
`define QUARTER_BASE 19'h60000
`define HALF_BASE 19'h40000

// block-guard codes
`define BG_NONE 2'h0
`define BG_QUARTER 2'h1
`define BG_HALF 2'h2

// frame byte positions
`define IDX_OPCODE 3'h0
`define IDX_FIRST_ARG 3'h1
`define IDX_ADDR_HI 3'h1
`define IDX_ADDR_MID 3'h2
`define IDX_ADDR_LO 3'h3
`define IDX_DATA 3'h4
`define BIT_LAST 3'h7

`endif

// >>> verilog/wp_decode_pkg.sv
// types shared by the serial memory write-protect decoder
`default_nettype none

package wp_decode_pkg;

  typedef enum logic [10:0] {
    CMD_IDLE = 11'h001,
    CMD_LATCH_SET = 11'h002,
    CMD_LATCH_CLEAR = 11'h004,
    CMD_STATUS_READ = 11'h008,
    CMD_STATUS_WRITE = 11'h010,
    CMD_MEM_READ = 11'h020,
    CMD_FAST_READ = 11'h040,
    CMD_MEM_WRITE = 11'h080,
    CMD_SLEEP = 11'h100,
    CMD_IDENT_READ = 11'h200,
    CMD_INVALID = 11'h400
  } cmd_t;

  typedef struct packed {
    logic guard_en;
    logic fixed_one;
    logic [1:0] fixed_hi;
    logic bg_hi;
    logic bg_lo;
    logic write_latch_flag;
    logic fixed_lo;
  } status_t;

  typedef struct packed {
    logic [18:0] addr;
    logic [7:0] data;
  } array_wr_t;

endpackage : wp_decode_pkg

`default_nettype wire

// >>> verilog/frame_sync.sv
// three-flop synchroniser that only passes a bit once its last two stages agree
`timescale 1ns/1ps
`default_nettype none

module frame_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output var logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;
  wire [WIDTH-1:0] agree = ~(s2 ^ s3);
  wire [WIDTH-1:0] next_q = (agree & s3) | (~agree & q);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= RESET_VAL;
      s2 <= RESET_VAL;
      s3 <= RESET_VAL;
      q <= RESET_VAL;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      q <= next_q;
    end
  end

endmodule : frame_sync

`default_nettype wire

// >>> verilog/spi_memory_write_protect_decode.sv
// opcode decode, write latch, status byte and write protection behind the serial port
//
// What this block does
// - opcode 06h sets the write latch, opcode 04h clears it.
// - opcodes 03h, 0Bh and 02h decode as read, fast read and memory write.
// - after power-up the write latch reads 0, so all writes are refused.
// - only the latch-set opcode sets the latch; status write data cannot set it.
// - latch clears when select rises after latch-clear, status write or memory write.
// - with the latch at 0, array and status writes are refused.
// - opcode 05h returns the status byte, most significant bit first.
// - opcode 01h plus data updates only pin-guard enable and both block-guard bits.
// - status bits 0, 4, 5 read 0, bit 6 reads 1, none writable.
// - status bit 7 pin-guard enable, bit 3/2 block guard, bit 1 latch.
// - block-guard bits survive power loss; shipped value of guard bits is 0.
// - guard code 00 none, 01 upper quarter, 10 upper half, 11 whole array.
// - writes into the guarded range always refused; others need the latch set.
// - with pin-guard enable at 0 the guard pin level is ignored.
// - enable at 1 and guard pin low refuses status writes, never array writes.
// - first byte after select falls is the opcode; one opcode per frame.
// - unknown opcode: rest of frame ignored, serial output stays off.
// - opcode B9h requests sleep once select rises.
// - opcode 9Fh decodes as the identification read.
`timescale 1ns/1ps
`default_nettype none
`include "wp_decode_params.svh"

module spi_memory_write_protect_decode (
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic SER_CLK,
  input wire logic CS_N,
  input wire logic SER_IN,
  input wire logic WR_GUARD_N,
  input wire logic [2:0] NV_GUARD_IN,
  output var logic SER_OUT,
  output var logic SER_OUT_OE,
  output var logic [2:0] NV_GUARD_OUT,
  output var logic [7:0] STATUS,
  output var wp_decode_pkg::cmd_t ACTIVE_CMD,
  output var wp_decode_pkg::array_wr_t ARRAY_WR,
  output var logic ARRAY_WR_STROBE,
  output var logic SLEEP_REQ
);

  // decodes the first byte of a frame into a command
  function automatic wp_decode_pkg::cmd_t decode_op(input logic [7:0] op);
    wp_decode_pkg::cmd_t c;
    c = wp_decode_pkg::CMD_INVALID;
    if (op == `OP_LATCH_SET) c = wp_decode_pkg::CMD_LATCH_SET;
    else if (op == `OP_LATCH_CLEAR) c = wp_decode_pkg::CMD_LATCH_CLEAR;
    else if (op == `OP_STATUS_READ) c = wp_decode_pkg::CMD_STATUS_READ;
    else if (op == `OP_STATUS_WRITE) c = wp_decode_pkg::CMD_STATUS_WRITE;
    else if (op == `OP_MEM_READ) c = wp_decode_pkg::CMD_MEM_READ;
    else if (op == `OP_FAST_READ) c = wp_decode_pkg::CMD_FAST_READ;
    else if (op == `OP_MEM_WRITE) c = wp_decode_pkg::CMD_MEM_WRITE;
    else if (op == `OP_SLEEP) c = wp_decode_pkg::CMD_SLEEP;
    else if (op == `OP_IDENT_READ) c = wp_decode_pkg::CMD_IDENT_READ;
    return c;
  endfunction : decode_op

  // true when the address lies in the block-guarded range
  function automatic logic guarded(input logic [1:0] code, input logic [18:0] a);
    logic g;
    g = 1'b1;
    if (code == `BG_NONE) g = 1'b0;
    else if (code == `BG_QUARTER) g = (a >= `QUARTER_BASE);
    else if (code == `BG_HALF) g = (a >= `HALF_BASE);
    return g;
  endfunction : guarded

  // ---------------- link side, clocked by the serial clock ----------------
  // select high clears the frame state without needing a clock edge,
  // because the serial clock may stop as soon as the frame ends
  wire link_rst = CS_N | ~NRST;

  logic [2:0] bit_cnt;
  logic [6:0] shift;
  logic op_done;
  logic arg_done;
  logic [7:0] link_op;
  logic byte_tgl;
  logic [7:0] byte_hold;
  logic so;
  logic so_oe;
  wp_decode_pkg::status_t status_snap;

  wire [7:0] rx_byte = {shift, SER_IN};
  wire byte_end = (bit_cnt == `BIT_LAST);
  wire status_phase = op_done & ~arg_done & (link_op == `OP_STATUS_READ);

  always_ff @(posedge SER_CLK or posedge link_rst) begin
    if (link_rst) begin
      bit_cnt <= 3'h0;
      shift <= 7'h00;
      op_done <= 1'b0;
      arg_done <= 1'b0;
      link_op <= 8'h00;
    end else begin
      bit_cnt <= bit_cnt + 3'h1;
      shift <= rx_byte[6:0];
      if (byte_end) begin
        op_done <= 1'b1;
        arg_done <= op_done;
      end
      if (byte_end && !op_done) begin
        link_op <= rx_byte;
      end
    end
  end

  // the held byte is stable for the next eight serial clocks,
  // long enough for the system side to read it after the toggle
  always_ff @(posedge SER_CLK or negedge NRST) begin
    if (!NRST) begin
      byte_tgl <= 1'b0;
      byte_hold <= 8'h00;
    end else if (byte_end) begin
      byte_tgl <= ~byte_tgl;
      byte_hold <= rx_byte;
    end
  end

  // output changes on the falling edge; only a status read ever drives it
  always_ff @(negedge SER_CLK or posedge link_rst) begin
    if (link_rst) begin
      so <= 1'b0;
      so_oe <= 1'b0;
    end else begin
      so_oe <= status_phase;
      so <= status_snap[~bit_cnt];
    end
  end

  assign SER_OUT = so;
  assign SER_OUT_OE = so_oe;

  // ---------------- system side ----------------
  logic [2:0] sync_q;

  frame_sync #(
    .WIDTH(3),
    .RESET_VAL(3'h6) // idle levels, so no false select or byte edge follows reset
  ) u_sync (
    .clk(SYS_CLK),
    .rst_n(NRST),
    .d({CS_N, WR_GUARD_N, byte_tgl}),
    .q(sync_q)
  );

  wire cs_n_s = sync_q[2];
  wire guard_pin_n_s = sync_q[1];
  wire tgl_s = sync_q[0];

  logic cs_prev;
  logic tgl_seen;
  logic frame_end;
  logic restored;
  logic write_latch_flag;
  logic guard_en;
  logic [1:0] block_guard;
  logic [2:0] byte_idx;
  logic [7:0] sw_data;
  logic sw_ok;
  logic [18:0] addr;
  logic stopped;
  logic sleep;
  wp_decode_pkg::cmd_t cmd;
  wp_decode_pkg::array_wr_t wr;
  logic wr_strobe;

  wire byte_ev = (tgl_s != tgl_seen);
  wire cs_fall = cs_prev & ~cs_n_s;
  // end actions run one cycle after select rises so a last byte seen
  // in the same cycle is already taken in
  wire cs_rise = ~cs_prev & cs_n_s;

  wire is_sw = (cmd == wp_decode_pkg::CMD_STATUS_WRITE);
  wire is_mw = (cmd == wp_decode_pkg::CMD_MEM_WRITE);
  wire first_byte = byte_ev & (byte_idx == `IDX_OPCODE);
  wire data_byte = byte_ev & is_mw & (byte_idx == `IDX_DATA);
  wire addr_guarded = guarded(block_guard, addr);

  // array write: latch set, address unguarded, no guarded address met yet
  wire wr_allowed = write_latch_flag & ~addr_guarded & ~stopped;
  // the pin counts only while its enable bit is set, and never for the array
  wire pin_blocks = guard_en & ~guard_pin_n_s;
  wire sw_allowed = write_latch_flag & sw_ok & ~pin_blocks;

  wire end_set = frame_end & (cmd == wp_decode_pkg::CMD_LATCH_SET);
  wire end_clear = frame_end & (is_sw | is_mw | (cmd == wp_decode_pkg::CMD_LATCH_CLEAR));
  wire next_wel = end_set | (write_latch_flag & ~end_clear);
  wire [18:0] next_addr = addr + `ADDR_ONE;
  wire [2:0] next_idx = (byte_idx == `IDX_DATA) ? byte_idx : byte_idx + 3'h1;

  wp_decode_pkg::status_t status_now;
  assign status_now = wp_decode_pkg::status_t'(`ST_FIXED_VALUE
    | ({7'h00, guard_en} << `ST_GUARD_EN_BIT)
    | ({7'h00, block_guard[1]} << `ST_BG_HI_BIT)
    | ({7'h00, block_guard[0]} << `ST_BG_LO_BIT)
    | ({7'h00, write_latch_flag} << `ST_WEL_BIT));

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      cs_prev <= 1'b1;
      tgl_seen <= 1'b0;
      frame_end <= 1'b0;
    end else begin
      cs_prev <= cs_n_s;
      tgl_seen <= tgl_s;
      frame_end <= cs_rise;
    end
  end

  // write latch comes up cleared and is never loaded from the status byte
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      write_latch_flag <= `WEL_RESET;
    end else begin
      write_latch_flag <= next_wel;
    end
  end

  // guard bits live in nonvolatile storage outside; they are restored
  // on the first clock after reset and mirrored back out on every change
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      restored <= 1'b0;
      guard_en <= 1'b0;
      block_guard <= 2'h0;
    end else if (!restored) begin
      restored <= 1'b1;
      guard_en <= NV_GUARD_IN[2];
      block_guard <= NV_GUARD_IN[1:0];
    end else if (frame_end && is_sw && sw_allowed) begin
      // only the writable bits are taken, the latch bit is dropped here
      guard_en <= sw_data[`ST_GUARD_EN_BIT];
      block_guard <= {sw_data[`ST_BG_HI_BIT], sw_data[`ST_BG_LO_BIT]};
    end
  end

  // command tracking across one frame
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      cmd <= wp_decode_pkg::CMD_IDLE;
      byte_idx <= `IDX_OPCODE;
      sw_data <= 8'h00;
      sw_ok <= 1'b0;
      stopped <= 1'b0;
    end else if (cs_fall) begin
      cmd <= wp_decode_pkg::CMD_IDLE;
      byte_idx <= `IDX_OPCODE;
      sw_ok <= 1'b0;
      stopped <= 1'b0;
    end else if (byte_ev) begin
      byte_idx <= next_idx;
      if (first_byte) begin
        cmd <= decode_op(byte_hold);
      end
      if (is_sw && byte_idx == `IDX_FIRST_ARG) begin
        sw_data <= byte_hold;
        sw_ok <= 1'b1;
      end
      if (data_byte && addr_guarded) begin
        stopped <= 1'b1;
      end
    end
  end

  // address assembly and array write strobes
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      addr <= `ADDR_ZERO;
      wr <= '0;
      wr_strobe <= 1'b0;
    end else begin
      wr_strobe <= data_byte & wr_allowed;
      if (byte_ev && is_mw) begin
        if (byte_idx == `IDX_ADDR_HI) addr <= {byte_hold[2:0], addr[15:0]};
        else if (byte_idx == `IDX_ADDR_MID) addr <= {addr[18:16], byte_hold, addr[7:0]};
        else if (byte_idx == `IDX_ADDR_LO) addr <= {addr[18:8], byte_hold};
        else if (wr_allowed) addr <= next_addr;
      end
      if (data_byte && wr_allowed) begin
        wr <= '{addr: addr, data: byte_hold};
      end
    end
  end

  // sleep request: raised when a sleep frame closes, dropped on next select
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      sleep <= 1'b0;
    end else if (cs_fall) begin
      sleep <= 1'b0;
    end else if (frame_end && cmd == wp_decode_pkg::CMD_SLEEP) begin
      sleep <= 1'b1;
    end
  end

  // the snapshot only moves while select is high, so the link side sees
  // a stable word for the whole frame; the eight opcode clocks cover the
  // four-cycle lag of the select synchroniser
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      status_snap <= wp_decode_pkg::status_t'(`STATUS_IDLE);
      STATUS <= `STATUS_IDLE;
    end else begin
      STATUS <= status_now;
      if (cs_n_s) begin
        status_snap <= status_now;
      end
    end
  end

  assign NV_GUARD_OUT = {guard_en, block_guard};
  assign ACTIVE_CMD = cmd;
  assign ARRAY_WR = wr;
  assign ARRAY_WR_STROBE = wr_strobe;
  assign SLEEP_REQ = sleep;

  // ---------------- checks ----------------
  sequence s_set_end;
    frame_end && cmd == wp_decode_pkg::CMD_LATCH_SET;
  endsequence

  sequence s_clear_end;
    frame_end && (is_sw || is_mw || cmd == wp_decode_pkg::CMD_LATCH_CLEAR);
  endsequence

  sequence s_status_op;
    first_byte && byte_hold == `OP_STATUS_READ;
  endsequence

  a_latch_set_end: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    s_set_end |=> write_latch_flag)
    else $error("latch not set after latch-set frame");

  a_latch_set_only: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    $rose(write_latch_flag) |-> $past(end_set))
    else $error("latch rose without a latch-set frame");

  a_latch_clear_end: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    s_clear_end |=> !write_latch_flag ##1 !write_latch_flag || cs_fall)
    else $error("latch not cleared at end of write frame");

  a_no_write_unlatched: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    wr_strobe |-> $past(write_latch_flag) && write_latch_flag)
    else $error("array write strobed with latch cleared");

  a_status_fixed_bits: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    (STATUS & ~`ST_WRITABLE_MASK & 8'hFD) == `ST_FIXED_VALUE)
    else $error("fixed status bits wrong");

  a_guard_range_kept: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    wr_strobe |-> !guarded(block_guard, wr.addr))
    else $error("write strobed inside guarded range");

  a_pin_refuses_status: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    frame_end && is_sw && restored && (!write_latch_flag || pin_blocks)
      |=> $stable(guard_en) && $stable(block_guard))
    else $error("refused status write changed guard bits");

  a_status_decode: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    s_status_op |=> cmd == wp_decode_pkg::CMD_STATUS_READ [*2])
    else $error("status-read opcode not decoded");

  a_output_quiet: assert property (@(posedge SER_CLK) disable iff (CS_N || !NRST)
    (link_op != `OP_STATUS_READ) |-> !so_oe)
    else $error("serial output driven outside a status read");

endmodule : spi_memory_write_protect_decode

`default_nettype wire

// >>> tb/spi_master_model.sv
// serial bus master model that drives the decoder's link pins in mode 0
`timescale 1ns/1ps
`default_nettype none

module spi_master_model (
  output wire logic ser_clk,
  output var logic cs_n,
  output var logic ser_in,
  input wire logic ser_out,
  input wire logic ser_out_oe
);
  logic lclk = 1'b0;
  logic run = 1'b0;
  initial cs_n = 1'b1;
  initial ser_in = 1'b0;
  always #24 lclk = ~lclk;
  // clock stands still outside frames; gating while low avoids runt pulses
  assign ser_clk = lclk & run;

  // each call is one select period carrying exactly one opcode
  task automatic xfer(input logic [47:0] tx, input int n, output logic [7:0] rx);
    rx = 8'hZZ;
    @(negedge lclk);
    cs_n = 1'b0;
    @(negedge lclk);
    for (int i = 0; i < n * 8; i++) begin
      ser_in = tx[47 - i];
      run = 1'b1;
      @(posedge lclk);
      if (i >= 8 && i < 16) rx[15 - i] = ser_out_oe ? ser_out : 1'bz;
      @(negedge lclk);
    end
    run = 1'b0;
    // deselected line shows the inverse of its last bit, not a held value
    ser_in = ~ser_in;
    cs_n = 1'b1;
    repeat (3) @(negedge lclk);
  endtask : xfer
endmodule : spi_master_model

`default_nettype wire

// >>> tb/spi_memory_write_protect_decode_tb_top.sv
// self-checking bench for the serial memory write-protect decoder
`timescale 1ns/1ps
`default_nettype none

module spi_memory_write_protect_decode_tb_top;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic wr_guard_n = 1'b1;
  logic [2:0] nv_guard_in = 3'h0;
  wire logic ser_clk, cs_n, ser_in;
  logic ser_out, ser_out_oe, array_wr_strobe, sleep_req;
  logic [2:0] nv_guard_out;
  logic [7:0] status, rx;
  wp_decode_pkg::cmd_t active_cmd;
  wp_decode_pkg::array_wr_t array_wr;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h1A726A86;
  logic [7:0] st_m = 8'h40;
  logic [7:0] exp_st[$];
  wp_decode_pkg::array_wr_t exp_wr[$];
  event rx_ev;
  logic [7:0] ops[13] = '{8'h06, 8'h05, 8'h04, 8'h01, 8'h03, 8'h0B, 8'h02, 8'hB9, 8'h9F,
    8'hC3, 8'hC2, 8'h5A, 8'h5B};
  logic [18:0] base[4] = '{19'h7FFFF, 19'h5FFFF, 19'h3FFFF, 19'h00000};
  int acc[4] = '{2, 1, 1, 0};

  always #2.5 sys_clk = ~sys_clk;

  spi_memory_write_protect_decode i_dut (
    .SYS_CLK(sys_clk),
    .NRST(nrst),
    .SER_CLK(ser_clk),
    .CS_N(cs_n),
    .SER_IN(ser_in),
    .WR_GUARD_N(wr_guard_n),
    .NV_GUARD_IN(nv_guard_in),
    .SER_OUT(ser_out),
    .SER_OUT_OE(ser_out_oe),
    .NV_GUARD_OUT(nv_guard_out),
    .STATUS(status),
    .ACTIVE_CMD(active_cmd),
    .ARRAY_WR(array_wr),
    .ARRAY_WR_STROBE(array_wr_strobe),
    .SLEEP_REQ(sleep_req)
  );

  spi_master_model i_master (
    .ser_clk(ser_clk),
    .cs_n(cs_n),
    .ser_in(ser_in),
    .ser_out(ser_out),
    .ser_out_oe(ser_out_oe)
  );

  function automatic logic [31:0] xorshift();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xorshift

  function automatic wp_decode_pkg::cmd_t exp_cmd(input logic [7:0] op);
    case (op)
      8'h06: return wp_decode_pkg::CMD_LATCH_SET;
      8'h04: return wp_decode_pkg::CMD_LATCH_CLEAR;
      8'h05: return wp_decode_pkg::CMD_STATUS_READ;
      8'h01: return wp_decode_pkg::CMD_STATUS_WRITE;
      8'h03: return wp_decode_pkg::CMD_MEM_READ;
      8'h0B: return wp_decode_pkg::CMD_FAST_READ;
      8'h02: return wp_decode_pkg::CMD_MEM_WRITE;
      8'hB9: return wp_decode_pkg::CMD_SLEEP;
      8'h9F: return wp_decode_pkg::CMD_IDENT_READ;
      default: return wp_decode_pkg::CMD_INVALID;
    endcase
  endfunction : exp_cmd

  task automatic check_val(input string what, input logic [26:0] exp, input logic [26:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check_val

  task automatic final_report();
    $display("checked %0d miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report

  // a second byte that is not a status read must find the output disabled
  task automatic frame(input logic [47:0] tx, input int n, input logic [7:0] nxt);
    if (n > 1) exp_st.push_back(tx[47:40] == 8'h05 ? st_m : 8'hZZ);
    st_m = nxt;
    i_master.xfer(tx, n, rx);
    if (n > 1) -> rx_ev;
    @(negedge sys_clk);
    check_val("status", 27'(st_m), 27'(status));
    check_val("guard out", 27'({st_m[7], st_m[3:2]}), 27'(nv_guard_out));
    check_val("command", 27'(exp_cmd(tx[47:40])), 27'(active_cmd));
    check_val("sleep", 27'(tx[47:40] == 8'hB9), 27'(sleep_req));
  endtask : frame

  task automatic pin(input logic v);
    @(negedge sys_clk);
    wr_guard_n = v;
  endtask : pin

  task automatic stat_write(input logic [7:0] d, input logic ok);
    frame({8'h06, 40'h0}, 1, st_m | 8'h02);
    frame({8'h01, d, 32'h0}, 2, ok ? (8'h40 | (d & 8'h8C)) : (st_m & 8'hFD));
  endtask : stat_write

  // top five address bits are sent as ones; they must not matter
  task automatic mem_write(input logic [18:0] a, input logic latch, input int nacc);
    logic [7:0] d0, d1;
    d0 = 8'(xorshift());
    d1 = 8'(xorshift());
    if (latch) frame({8'h06, 40'h0}, 1, st_m | 8'h02);
    for (int k = 0; k < nacc; k++) exp_wr.push_back({a + 19'(k), k > 0 ? d1 : d0});
    frame({8'h02, 5'h1F, a, d0, d1}, 6, st_m & 8'hFD);
  endtask : mem_write

  always @(rx_ev) check_val("read byte", 27'(exp_st.pop_front()), 27'(rx));

  always @(negedge sys_clk) begin
    cycles <= cycles + 1;
    if (array_wr_strobe === 1'b1)
      check_val("array write", exp_wr.size() > 0 ? 27'(exp_wr.pop_front()) : ~27'(array_wr),
        27'(array_wr));
    if (cycles == 60000) begin
      miscompares++;
      final_report();
    end
  end

  initial begin
    repeat (20) @(negedge sys_clk);
    nrst = 1'b1;
    repeat (8) @(negedge sys_clk);
    check_val("reset status", 27'h40, 27'(status));
    foreach (ops[i])
      frame({ops[i], 8'h05, 32'h0}, 2, ops[i] == 8'h06 ? (st_m | 8'h02) :
        (ops[i] inside {8'h04, 8'h01, 8'h02}) ? (st_m & 8'hFD) : st_m);
    frame({8'h01, 8'hFF, 32'h0}, 2, st_m);
    stat_write(8'hFF, 1'b1);
    pin(1'b0);
    stat_write(8'h00, 1'b0);
    for (int c = 0; c < 4; c++) begin
      pin(1'b1);
      stat_write({1'b1, 3'h0, 2'(c), 2'h0}, 1'b1);
      pin(1'b0);
      mem_write(c == 3 ? 19'(xorshift()) : base[c], 1'b1, acc[c]);
    end
    pin(1'b1);
    stat_write(8'h08, 1'b1);
    pin(1'b0);
    stat_write(8'h04, 1'b1);
    mem_write(19'(xorshift()) & 19'h3FFF0, 1'b0, 0);
    mem_write(19'(xorshift()) & 19'h3FFF0, 1'b1, 2);
    @(negedge sys_clk);
    nrst = 1'b0;
    nv_guard_in = 3'h5;
    repeat (4) @(negedge sys_clk);
    nrst = 1'b1;
    st_m = 8'hC4;
    repeat (8) @(negedge sys_clk);
    frame({8'h05, 40'h0}, 2, 8'hC4);
    check_val("pending writes", 27'h0, 27'(exp_wr.size()));
    final_report();
  end
endmodule : spi_memory_write_protect_decode_tb_top

`default_nettype wire
